// ===== src/psm_pkg.sv
// Constants and types for the power saving mode control block
//==============================================================
package psm_pkg;

	//==============================================================
	// Register map (index times four is the byte address)
	localparam logic [9:0]  PSM_PWR_CTRL_IDX = 10'h087;
	localparam logic [9:0]  PSM_STAT_IDX   = 10'h088;
	localparam int          PSM_ADDR_W     = 12;

	//==============================================================
	// Power control register fields
	localparam int          PSM_SMOD_BIT   = 7;
	localparam int          PSM_PD_START_BIT = 6;
	localparam int          PSM_IDS_BIT    = 5;
	localparam int          PSM_PD_ARM_BIT = 1;
	localparam int          PSM_IDE_BIT    = 0;
	localparam logic [7:0]  PSM_KEEP_MASK  = 8'h8c;
	localparam logic [7:0]  PSM_PWR_CTRL_RST = 8'h00;

	//==============================================================
	// Types
	typedef enum logic [1:0] {
		PSM_ACTIVE,
		PSM_IDLE,
		PSM_PDOWN
	} psm_mode_t;

	typedef struct packed {
		logic       ale;
		logic       code_fetch_strobe;
		logic [7:0] port;
	} psm_pins_t;

endpackage // psm_pkg

// ===== src/psm_ctrl.sv
// Power saving mode controller with APB access to the power control register
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module psm_ctrl
	import psm_pkg::*;
#(
	parameter int PORT_W = 8
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [PSM_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  irq_pending,
	input  wire psm_pins_t             core_pins,
	input  wire logic [PORT_W-1:0]     alt_sel,
	input  wire logic [PORT_W-1:0]     alt_value,
	output psm_pins_t                  pins_out,
	output logic                       osc_en,
	output logic                       cpu_clk_en,
	output logic                       periph_clk_en,
	output logic                       wdt_clk_en,
	output logic                       baud_double,
	output psm_mode_t                  mode
);

	//==============================================================
	// Bus decode
	//==============================================================
	// Every access completes in one access cycle
	wire logic        acc_phase;
	wire logic        hit_ctrl;
	wire logic        hit_stat;
	wire logic        wr_ctrl;
	wire logic [7:0]  wbyte;

	assign acc_phase = psel & penable;
	assign hit_ctrl  = (paddr[PSM_ADDR_W-1:2] == PSM_PWR_CTRL_IDX);
	assign hit_stat  = (paddr[PSM_ADDR_W-1:2] == PSM_STAT_IDX);
	assign pready    = 1'b1;
	assign pslverr   = acc_phase & ~(hit_ctrl | hit_stat);
	// Writes are dropped while the CPU clock is stopped
	assign wr_ctrl   = acc_phase & pwrite & hit_ctrl & (mode == PSM_ACTIVE);
	assign wbyte     = pwdata[7:0];

	//==============================================================
	// Entry sequence detection
	//==============================================================
	logic             pd_armed_reg;
	logic             id_armed_reg;
	logic [7:0]       keep_reg;
	wire logic        w_pd_arm;
	wire logic        w_pd_start;
	wire logic        w_id_arm;
	wire logic        w_id_start;
	wire logic        pd_go;
	wire logic        id_go;

	assign w_pd_arm   = wbyte[PSM_PD_ARM_BIT];
	assign w_pd_start = wbyte[PSM_PD_START_BIT];
	assign w_id_arm   = wbyte[PSM_IDE_BIT];
	assign w_id_start = wbyte[PSM_IDS_BIT];
	// Start only after an arming write, never with the arm bit in the same write
	assign pd_go = wr_ctrl & pd_armed_reg & w_pd_start & ~w_pd_arm;
	// Power-down wins over a concurrent idle start
	assign id_go = wr_ctrl & id_armed_reg & w_id_start & ~w_id_arm & ~pd_go;

	// Arm flags live for exactly one following control write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_armed_reg <= 1'b0;
			id_armed_reg <= 1'b0;
		end else if (wr_ctrl) begin
			pd_armed_reg <= w_pd_arm & ~w_pd_start;
			id_armed_reg <= w_id_arm & ~w_id_start;
		end
	end

	// Retained fields: baud doubling and the two general flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			keep_reg <= PSM_PWR_CTRL_RST;
		end else if (wr_ctrl) begin
			keep_reg <= wbyte & PSM_KEEP_MASK;
		end
	end

	assign baud_double = keep_reg[PSM_SMOD_BIT];

	//==============================================================
	// Mode state
	//==============================================================
	psm_mode_t        mode_next;

	// Entry on the start write, exit from idle on interrupt or reset
	always_comb begin
		mode_next = mode;
		case (mode)
			PSM_ACTIVE: begin
				if (pd_go) begin
					mode_next = PSM_PDOWN;
				end else if (id_go) begin
					mode_next = PSM_IDLE;
				end
			end
			PSM_IDLE: begin
				if (irq_pending) begin
					mode_next = PSM_ACTIVE;
				end
			end
			PSM_PDOWN: begin
				mode_next = PSM_PDOWN;
			end
			default: begin
				mode_next = PSM_ACTIVE;
			end
		endcase
	end

	// Reset is the only way out of power-down and also ends idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= PSM_ACTIVE;
		end else begin
			mode <= mode_next;
		end
	end

	//==============================================================
	// Clock gating
	//==============================================================
	// Oscillator off only in power-down; idle gates CPU and watchdog
	assign osc_en        = (mode != PSM_PDOWN);
	assign cpu_clk_en    = (mode == PSM_ACTIVE);
	assign periph_clk_en = (mode != PSM_PDOWN);
	assign wdt_clk_en    = (mode == PSM_ACTIVE);

	//==============================================================
	// Pin control
	//==============================================================
	logic [PORT_W-1:0] alt_hold_reg;
	wire logic [PORT_W-1:0] port_next;
	logic              ale_next;
	logic              strobe_next;
	wire psm_pins_t    pins_next;

	// Alternate outputs frozen at the end of the power-down start write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alt_hold_reg <= '0;
		end else if (pd_go) begin
			alt_hold_reg <= alt_value;
		end
	end

	// Per-bit choice between port latch and alternate function
	genvar gi;
	generate
		for (gi = 0; gi < PORT_W; gi++) begin : g_port
			assign port_next[gi] = (mode == PSM_PDOWN)
				? (alt_sel[gi] ? alt_hold_reg[gi] : core_pins.port[gi])
				: (alt_sel[gi] ? alt_value[gi] : core_pins.port[gi]);
		end
	endgenerate

	// Strobe levels per mode
	always_comb begin
		case (mode)
			PSM_IDLE: begin
				ale_next    = 1'b1;
				strobe_next = 1'b1;
			end
			PSM_PDOWN: begin
				ale_next    = 1'b0;
				strobe_next = 1'b0;
			end
			default: begin
				ale_next    = core_pins.ale;
				strobe_next = core_pins.code_fetch_strobe;
			end
		endcase
	end

	// One driver for the whole next pin word
	assign pins_next = '{ale: ale_next, code_fetch_strobe: strobe_next, port: port_next};

	// Registered pin drivers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_out <= '0;
		end else begin
			pins_out <= pins_next;
		end
	end

	//==============================================================
	// Read data
	//==============================================================
	wire logic [31:0] rd_ctrl;
	wire logic [31:0] rd_stat;

	// Self-clearing arm and start bits always read zero
	assign rd_ctrl = {24'h000000, keep_reg};
	assign rd_stat = {28'h0000000, id_armed_reg, pd_armed_reg, mode};

	// Read data latched in the setup cycle, held into the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= hit_ctrl ? rd_ctrl : (hit_stat ? rd_stat : 32'h00000000);
		end
	end

	//==============================================================
	// Assertions
	//==============================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Last accepted control byte, an independent view of arming
	logic [7:0]       last_wr_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_wr_reg <= 8'h00;
		end else if (wr_ctrl) begin
			last_wr_reg <= wbyte;
		end
	end

	sequence s_pd_arm;
		wr_ctrl && w_pd_arm && !w_pd_start;
	endsequence

	sequence s_pd_start;
		wr_ctrl && w_pd_start && !w_pd_arm;
	endsequence

	sequence s_prev_pd_arm;
		last_wr_reg[PSM_PD_ARM_BIT] && !last_wr_reg[PSM_PD_START_BIT];
	endsequence

	a_pd_pair_entry: assert property (s_prev_pd_arm ##0 s_pd_start |=> mode == PSM_PDOWN)
		else $error("power-down not entered after arm then start");

	a_pd_arm_flag: assert property (s_pd_arm |=> pd_armed_reg)
		else $error("arming write did not arm power-down");

	a_pd_no_stale: assert property (s_pd_start ##0 !last_wr_reg[PSM_PD_ARM_BIT] |=> mode != PSM_PDOWN)
		else $error("power-down started without arming write just before");

	a_pd_both_bits: assert property ((mode == PSM_ACTIVE) && wr_ctrl && w_pd_arm && w_pd_start |=> mode == PSM_ACTIVE)
		else $error("combined arm and start entered power-down");

	a_id_both_bits: assert property ((mode == PSM_ACTIVE) && wr_ctrl && w_id_arm && w_id_start |=> mode != PSM_IDLE)
		else $error("combined idle enable and start entered idle");

	a_read_bits_zero: assert property (acc_phase && !pwrite && hit_ctrl |-> prdata[6:5] == 2'b00 && prdata[1:0] == 2'b00)
		else $error("self-clearing bit read back as one");

	a_pd_no_exit: assert property (mode == PSM_PDOWN && irq_pending |=> mode == PSM_PDOWN)
		else $error("power-down left without reset");

	a_pd_strobes_low: assert property (mode == PSM_PDOWN |=> !pins_out.ale && !pins_out.code_fetch_strobe)
		else $error("strobes not low in power-down");

	a_idle_strobes_high: assert property (mode == PSM_IDLE |=> pins_out.ale && pins_out.code_fetch_strobe)
		else $error("strobes not high in idle");

	a_idle_irq_exit: assert property (mode == PSM_IDLE && irq_pending |=> mode == PSM_ACTIVE ##0 cpu_clk_en)
		else $error("interrupt did not end idle");

	a_pd_precedence: assert property (pd_go && wr_ctrl && id_armed_reg && w_id_start |=> mode == PSM_PDOWN)
		else $error("idle taken over power-down");

	a_pd_clocks_off: assert property (mode == PSM_PDOWN |-> !osc_en && !cpu_clk_en && !periph_clk_en)
		else $error("clock running in power-down");

	a_idle_clocks: assert property (mode == PSM_IDLE |-> osc_en && periph_clk_en && !cpu_clk_en && !wdt_clk_en)
		else $error("wrong clock gating in idle");

	a_pd_alt_hold: assert property (pd_go ##1 (mode == PSM_PDOWN && alt_sel[0]) |=> pins_out.port[0] == $past(alt_value[0], 2))
		else $error("alternate pin did not hold its value");

	a_arm_discard: assert property (s_prev_pd_arm ##0 (wr_ctrl && !w_pd_arm) |=> !pd_armed_reg)
		else $error("stale power-down arming kept");

endmodule // psm_ctrl

`default_nettype wire

// ===== test/test_power_saving_mode_control.sv
// Self-checking bench for the power saving mode controller
`timescale 1ns/100ps
`default_nettype none

module test_power_saving_mode_control;
	import psm_pkg::*;

	//==============================================================
	// Stimulus and observation signals
	logic                  pclk, presetn, psel, penable, pwrite, irq_pending;
	logic                  pready, pslverr, osc_en, cpu_clk_en, periph_clk_en, wdt_clk_en, baud_double;
	logic [PSM_ADDR_W-1:0] paddr;
	logic [31:0]           pwdata, prdata, rd;
	logic [7:0]            alt_sel, alt_value;
	psm_pins_t             core_pins, pins_out;
	psm_mode_t             mode;
	logic                  err;
	int                    failures, checks_done;
	localparam logic [11:0] CTRL_A = {PSM_PWR_CTRL_IDX, 2'b00};
	localparam logic [11:0] STAT_A = {PSM_STAT_IDX, 2'b00};

	psm_ctrl #(.PORT_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_pending(irq_pending), .core_pins(core_pins), .alt_sel(alt_sel),
		.alt_value(alt_value), .pins_out(pins_out), .osc_en(osc_en), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .wdt_clk_en(wdt_clk_en), .baud_double(baud_double), .mode(mode));

	//==============================================================
	// Clock, checks and bus cycles
	always #10 pclk = ~pclk;

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Setup cycle, access until pready, then release and idle one edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic hw_reset(input int n);
		presetn <= 1'b0;
		tick(n);
		presetn <= 1'b1;
		tick(2);
	endtask

	task automatic clocks(input logic [3:0] exp);
		chk("clock enables", {28'h0, exp}, {28'h0, osc_en, cpu_clk_en, periph_clk_en, wdt_clk_en});
	endtask

	//==============================================================
	// Scenarios
	task automatic t_fields;
		apb(1'b1, CTRL_A, 8'h42);
		tick(2);
		chk("mode after pd arm+start", PSM_ACTIVE, mode);
		apb(1'b1, CTRL_A, 8'h21);
		tick(2);
		chk("mode after idle arm+start", PSM_ACTIVE, mode);
		apb(1'b1, CTRL_A, 8'hff);
		tick(2);
		chk("mode after all ones", PSM_ACTIVE, mode);
		apb(1'b0, CTRL_A, 8'h00);
		chk("control readback", 32'h8c, rd);
		chk("mapped error", 32'h0, {31'h0, err});
		chk("baud double", 32'h1, {31'h0, baud_double});
		apb(1'b1, CTRL_A, 8'h00);
		apb(1'b0, 12'h004, 8'h00);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
	endtask

	// Start write carries the flag as an OR write would; arming was lost
	task automatic t_discard;
		apb(1'b1, CTRL_A, 8'h02);
		apb(1'b0, STAT_A, 8'h00);
		chk("armed flag", 32'h4, rd & 32'h4);
		apb(1'b1, CTRL_A, 8'h04);
		apb(1'b1, CTRL_A, 8'h44);
		tick(2);
		chk("mode after lost arm", PSM_ACTIVE, mode);
		apb(1'b0, CTRL_A, 8'h00);
		chk("flag kept", 32'h04, rd);
		apb(1'b1, CTRL_A, 8'h00);
	endtask

	task automatic t_idle;
		apb(1'b1, CTRL_A, 8'h01);
		apb(1'b1, CTRL_A, 8'h20);
		tick(2);
		chk("idle mode", PSM_IDLE, mode);
		clocks(4'b1010);
		// Strobes high; port a6 with low nibble from alternate value 05
		chk("idle pins", 32'h3a5, {22'h0, pins_out});
		irq_pending <= 1'b1;
		tick(3);
		chk("idle wake", PSM_ACTIVE, mode);
		clocks(4'hf);
		irq_pending <= 1'b0;
		apb(1'b1, CTRL_A, 8'h01);
		apb(1'b1, CTRL_A, 8'h20);
		tick(2);
		hw_reset(2);
		chk("idle reset exit", PSM_ACTIVE, mode);
	endtask

	// OR writes keep the baud bit set through the start write
	task automatic t_pdown;
		apb(1'b1, CTRL_A, 8'h82);
		apb(1'b1, CTRL_A, 8'hc0);
		alt_value <= 8'h0a;
		tick(3);
		chk("pd mode", PSM_PDOWN, mode);
		clocks(4'h0);
		chk("pd pins", 32'h0a5, {22'h0, pins_out});
		irq_pending <= 1'b1;
		apb(1'b1, CTRL_A, 8'h00);
		tick(2);
		chk("pd after irq", PSM_PDOWN, mode);
		chk("pd regs kept", 32'h1, {31'h0, baud_double});
		irq_pending <= 1'b0;
		alt_value <= 8'h05;
		hw_reset(3);
		chk("pd reset exit", PSM_ACTIVE, mode);
		clocks(4'hf);
		apb(1'b0, CTRL_A, 8'h00);
		chk("pd reset value", 32'h0, rd);
		apb(1'b1, CTRL_A, 8'h03);
		apb(1'b1, CTRL_A, 8'h60);
		tick(2);
		chk("both starts", PSM_PDOWN, mode);
		hw_reset(2);
	endtask

	//==============================================================
	// Verdict, watchdog and main sequence
	task automatic complete_run;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		tick(3000);
		failures++;
		complete_run();
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, irq_pending} = '0;
		paddr = '0;
		pwdata = '0;
		core_pins = '{ale: 1'b1, code_fetch_strobe: 1'b0, port: 8'ha6};
		alt_sel = 8'h0f;
		alt_value = 8'h05;
		failures = 0;
		checks_done = 0;
		tick(10);
		presetn <= 1'b1;
		tick(2);
		chk("reset mode", PSM_ACTIVE, mode);
		clocks(4'hf);
		chk("ready", 32'h1, {31'h0, pready});
		// Active pins follow the core, low nibble from alternate value
		chk("active pins", 32'h2a5, {22'h0, pins_out});
		t_fields();
		t_discard();
		t_idle();
		t_pdown();
		complete_run();
	end

endmodule // test_power_saving_mode_control

`default_nettype wire
